//--- rtl/xcvr_regs_defs.vh
// register offsets, field positions and reset values of the transceiver management registers
`ifndef XCVR_REGS_DEFS_VH
`define XCVR_REGS_DEFS_VH

`define OFS_MODE_CONTROL    8'hD0
`define OFS_EVENT_STATUS    8'hD4
`define OFS_EVENT_ENABLE    8'hD8
`define OFS_FAST_TX_CONTROL 8'hDC

`define BIT_LONG_SQUELCH    11
`define BIT_SPEED           9
`define BIT_DUPLEX          8
`define BIT_PAUSE           7
`define BIT_AN_DONE         6
`define BIT_REMOTE_FAULT    5
`define BIT_LINK_DOWN       4
`define BIT_AN_ACK          3
`define BIT_PAR_FAULT       2
`define BIT_AN_PAGE         1
`define BIT_RX_ERR_FULL     0
`define BIT_RXERR_OFF       13
`define BIT_AN_MIRROR       12

`define NUM_EVENTS          7
`define RX_ERR_LIMIT        7'h40
`define EVENT_ENABLE_RST    7'h00

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

//--- rtl/event_latch.v
// latched-high event flags that clear on a status read, set winning over clear
`timescale 1ns/1ps
module event_latch (
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // event sources and read clear
  input  wire [5:0] event_in,
  input  wire       read_clear,
  // latched flags
  output wire [5:0] flags
);

  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_flag
      // one flop per flag keeps every bit with a single driver
      reg flag_r;

      always @(posedge aclk) begin
        if (!aresetn)
          flag_r <= 1'b0;
        else if (event_in[i])
          flag_r <= 1'b1;
        else if (read_clear)
          flag_r <= 1'b0;
      end

      assign flags[i] = flag_r;
    end
  endgenerate

endmodule // event_latch

//--- rtl/rx_error_counter.v
// counter of errored receive packets, saturating at the full limit
`timescale 1ns/1ps
`include "xcvr_regs_defs.vh"
module rx_error_counter (
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // count control
  input  wire       rx_err_pkt,
  input  wire       counter_off,
  input  wire       clear,
  // state
  output wire [6:0] count,
  output wire       full
);

  reg [6:0] count_r;

  always @(posedge aclk) begin
    if (!aresetn)
      count_r <= 7'h00;
    else if (clear)
      count_r <= 7'h00;
    else if (rx_err_pkt && !counter_off && count_r != `RX_ERR_LIMIT)
      count_r <= count_r + 7'h01;
  end

  assign count = count_r;
  assign full  = (count_r == `RX_ERR_LIMIT);

endmodule // rx_error_counter

//--- rtl/phy_mode_status_interrupt_regs.v
// transceiver mode, configuration status, event interrupt and 100BASE-TX control registers
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "xcvr_regs_defs.vh"
module phy_mode_status_interrupt_regs (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // transceiver state
  input  wire        speed_100,
  input  wire        full_duplex,
  input  wire        pause_enabled,
  input  wire        link_up,
  input  wire        autoneg_complete,
  // transceiver events, one-cycle pulses
  input  wire        remote_fault_evt,
  input  wire        autoneg_ack_evt,
  input  wire        parallel_fault_evt,
  input  wire        autoneg_page_evt,
  input  wire        rx_error_pkt,
  input  wire        rx_error_clear,
  // transceiver control
  output wire        long_cable_squelch,
  output wire        rx_error_counter_off,
  output wire        xcvr_irq
);

  reg         long_cable_squelch_r;
  reg         rx_error_counter_off_r;
  reg  [6:0]  event_enable_r;
  reg         link_up_r;
  reg         an_done_r;
  reg         cfg_valid_r;

  reg  [7:0]  aw_addr_r;
  reg         aw_held_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         w_held_r;
  reg         bvalid_r;
  reg  [1:0]  bresp_r;
  reg         rvalid_r;
  reg  [31:0] rdata_r;
  reg  [1:0]  rresp_r;

  reg  [15:0] rd_word;
  reg         rd_hit;
  reg         wr_hit;

  wire        do_write;
  wire        do_read;
  wire        status_read;
  wire        link_fell;
  wire        an_rose;
  wire [5:0]  latched;
  wire        err_full;
  wire [6:0]  status_events;

  // write channels are taken independently and held until both are present
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign do_write      = aw_held_r && w_held_r && !bvalid_r;
  assign do_read       = s_axi_arvalid && !rvalid_r;

  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_r <= 8'h00;
      aw_held_r <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      w_held_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_held_r <= 1'b1;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always @* begin
    case (aw_addr_r)
      `OFS_MODE_CONTROL, `OFS_EVENT_STATUS, `OFS_EVENT_ENABLE, `OFS_FAST_TX_CONTROL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // writable fields; only fields in the low two byte lanes exist
  always @(posedge aclk) begin
    if (!aresetn) begin
      long_cable_squelch_r   <= 1'b0;
      rx_error_counter_off_r <= 1'b0;
      event_enable_r         <= `EVENT_ENABLE_RST;
    end else if (do_write) begin
      if (aw_addr_r == `OFS_MODE_CONTROL && w_strb_r[1])
        long_cable_squelch_r <= w_data_r[`BIT_LONG_SQUELCH];
      if (aw_addr_r == `OFS_EVENT_ENABLE && w_strb_r[0])
        event_enable_r <= w_data_r[6:0];
      if (aw_addr_r == `OFS_FAST_TX_CONTROL && w_strb_r[1])
        rx_error_counter_off_r <= w_data_r[`BIT_RXERR_OFF];
    end
  end

  assign long_cable_squelch   = long_cable_squelch_r;
  assign rx_error_counter_off = rx_error_counter_off_r;

  // edge detection of link and negotiation levels
  always @(posedge aclk) begin
    if (!aresetn) begin
      link_up_r   <= 1'b0;
      an_done_r   <= 1'b0;
      cfg_valid_r <= 1'b0;
    end else begin
      link_up_r   <= link_up;
      an_done_r   <= autoneg_complete;
      cfg_valid_r <= 1'b1;
    end
  end

  assign link_fell   = link_up_r && !link_up;
  assign an_rose     = autoneg_complete && !an_done_r;
  assign status_read = do_read && (s_axi_araddr == `OFS_EVENT_STATUS);

  event_latch u_event_latch (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .event_in   ({an_rose, remote_fault_evt, link_fell,
                  autoneg_ack_evt, parallel_fault_evt, autoneg_page_evt}),
    .read_clear (status_read),
    .flags      (latched)
  );

  rx_error_counter u_rx_error_counter (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .rx_err_pkt  (rx_error_pkt),
    .counter_off (rx_error_counter_off_r),
    .clear       (rx_error_clear),
    .count       (),
    .full        (err_full)
  );

  // bit 0 is a level from the counter, bits 6..1 are latched flags
  assign status_events = {latched, err_full};
  assign xcvr_irq      = |(status_events & event_enable_r);

  // read mux; speed reads as 1 until the first sampled value
  always @* begin
    rd_word = 16'h0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `OFS_MODE_CONTROL:
        rd_word[`BIT_LONG_SQUELCH] = long_cable_squelch_r;
      `OFS_EVENT_STATUS: begin
        rd_word[`BIT_SPEED]  = cfg_valid_r ? speed_100 : 1'b1;
        rd_word[`BIT_DUPLEX] = cfg_valid_r ? full_duplex : 1'b0;
        rd_word[`BIT_PAUSE]  = cfg_valid_r ? pause_enabled : 1'b0;
        rd_word[6:0]         = status_events;
      end
      `OFS_EVENT_ENABLE:
        rd_word[6:0] = event_enable_r;
      `OFS_FAST_TX_CONTROL: begin
        rd_word[`BIT_RXERR_OFF] = rx_error_counter_off_r;
        rd_word[`BIT_AN_MIRROR] = autoneg_complete;
      end
      default:
        rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `RESP_OKAY;
    end else if (do_read) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {16'h0000, rd_word};
      rresp_r  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule // phy_mode_status_interrupt_regs

//--- verification/phy_regs_sva.sv
// bus handshake and control output checker for the transceiver register bank
`timescale 1ns/1ps
module phy_regs_sva (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // control output
  input wire logic        long_cable_squelch
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_both;
  assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  function automatic logic mapped(input logic [7:0] a);
    return a == 8'hD0 || a == 8'hD4 || a == 8'hD8 || a == 8'hDC;
  endfunction
  a_squelch_write: assert property (wr_both && s_axi_awaddr == 8'hD0 && s_axi_wstrb[1]
    |-> ##2 long_cable_squelch == $past(s_axi_wdata[11], 2)) else $error("squelch does not follow write");
  a_write_resp: assert property (wr_both
    |-> ##2 s_axi_bvalid && s_axi_bresp == (mapped($past(s_axi_awaddr, 2)) ? 2'h0 : 2'h2)) else $error("bad bresp");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && s_axi_rresp == (mapped($past(s_axi_araddr)) ? 2'h0 : 2'h2)) else $error("bad rresp");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper half set");
  a_ar_refuse: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
  a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  c_write: cover property (wr_both ##2 s_axi_bvalid);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_rstall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // phy_regs_sva

bind phy_mode_status_interrupt_regs phy_regs_sva phy_regs_sva_i (.*);

//--- verification/link_partner_model.sv
// link partner model: line state levels and negotiation event pulses
`timescale 1ns/1ps
module link_partner_model (
  // clock
  input  wire logic  aclk,
  // line state; events are remote fault, acknowledge, parallel fault, page
  output logic       speed_100,
  output logic       full_duplex,
  output logic       pause_enabled,
  output logic       link_up,
  output logic       autoneg_complete,
  output logic [3:0] evt
);
  initial {speed_100, full_duplex, pause_enabled, link_up, autoneg_complete, evt} = 9'h120;
  // levels change after an edge, then settle a few cycles
  task automatic state(input logic [4:0] s);
    @(posedge aclk) {speed_100, full_duplex, pause_enabled, link_up, autoneg_complete} <= s;
    repeat (3) @(posedge aclk);
  endtask
  task automatic pulse(input logic [3:0] e);
    @(posedge aclk) evt <= e;
    @(posedge aclk) evt <= 4'h0;
  endtask
endmodule // link_partner_model

//--- verification/phy_mode_status_interrupt_regs_tb_top.sv
// self-checking bench for the transceiver register bank
`timescale 1ns/1ps
module phy_mode_status_interrupt_regs_tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, speed_100, full_duplex, pause_enabled, link_up;
  logic autoneg_complete, rx_error_pkt, rx_error_clear, long_cable_squelch, rx_error_counter_off, xcvr_irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, evt;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire         remote_fault_evt, autoneg_ack_evt, parallel_fault_evt, autoneg_page_evt;
  int          n_errors = 0, tests_run = 0;
  assign {remote_fault_evt, autoneg_ack_evt, parallel_fault_evt, autoneg_page_evt} = evt;
  phy_mode_status_interrupt_regs phy_mode_status_interrupt_regs_i (.*);
  link_partner_model link_partner_model_i (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %h expected %h", $time, g, e);
    end
  endtask
  task automatic results;
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one transfer; responses are accepted two cycles after they appear
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                     input logic [31:0] ed);
    int   n;
    logic ta, tw, tar, tb, tr;
    @(posedge aclk);
    if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
    else {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      if (w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready) break;
      {ta, tw, tar, tb, tr} = {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid};
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tar) s_axi_arvalid <= 1'b0;
      s_axi_bready <= tb;
      s_axi_rready <= tr;
    end
    if (n == 50) begin
      n_errors++;
      results;
    end
    chk(w ? s_axi_bresp : s_axi_rresp, er);
    if (!w) chk(s_axi_rdata, ed);
    @(posedge aclk);
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e); bus(1'b0, a, 32'h0, 2'h0, e); endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d, 2'h0, 32'h0); endtask
  task automatic irq(input logic e);
    @(negedge aclk);
    chk(xcvr_irq, e);
  endtask
  task automatic pk(input int n);
    repeat (n) begin
      @(posedge aclk) rx_error_pkt <= 1'b1;
      @(posedge aclk) rx_error_pkt <= 1'b0;
    end
  endtask
  task automatic t_regs;
    irq(1'b0);
    rd(8'hD0, 32'h0);
    rd(8'hD4, 32'h200);
    rd(8'hD8, 32'h0);
    rd(8'hDC, 32'h0);
    wr(8'hD0, 32'hFFFF_FFFF);
    rd(8'hD0, 32'h800);
    chk(long_cable_squelch, 1'b1);
    wr(8'hD4, 32'hFFFF_FFFF);
    rd(8'hD4, 32'h200);
    bus(1'b1, 8'hE0, 32'hFFFF_FFFF, 2'h2, 32'h0);
    bus(1'b0, 8'hE0, 32'h0, 2'h2, 32'h0);
    link_partner_model_i.state(5'h0E);
    rd(8'hD4, 32'h180);
  endtask
  task automatic t_events;
    int b[4] = '{1, 2, 3, 5};
    wr(8'hD8, 32'hFFFF_FFFF);
    rd(8'hD8, 32'h7F);
    for (int i = 0; i < 4; i++) begin
      link_partner_model_i.pulse(4'h1 << i);
      irq(1'b1);
      rd(8'hD4, 32'h180 | (32'h1 << b[i]));
      irq(1'b0);
    end
    link_partner_model_i.state(5'h0C);
    rd(8'hD4, 32'h190);
    link_partner_model_i.state(5'h0E);
    rd(8'hD4, 32'h180);
    link_partner_model_i.state(5'h0F);
    rd(8'hDC, 32'h1000);
    rd(8'hD4, 32'h1C0);
    wr(8'hD8, 32'h0);
    link_partner_model_i.pulse(4'h8);
    irq(1'b0);
    rd(8'hD4, 32'h1A0);
  endtask
  task automatic t_rxerr;
    wr(8'hDC, 32'h2000);
    rd(8'hDC, 32'h3000);
    chk(rx_error_counter_off, 1'b1);
    pk(64);
    rd(8'hD4, 32'h180);
    wr(8'hDC, 32'h0);
    pk(63);
    rd(8'hD4, 32'h180);
    pk(1);
    rd(8'hD4, 32'h181);
    wr(8'hD8, 32'h1);
    irq(1'b1);
    @(posedge aclk) rx_error_clear <= 1'b1;
    @(posedge aclk) rx_error_clear <= 1'b0;
    rd(8'hD4, 32'h180);
    irq(1'b0);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rx_error_pkt, rx_error_clear} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, aresetn} = 55'h0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_events;
    t_rxerr;
    results;
  end
endmodule // phy_mode_status_interrupt_regs_tb_top
